// ### rtl/lpm_pkg.sv
package lpm_pkg;
    // ------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] LPM_CTRL_OFS = 8'h00;
    localparam logic [7:0] LPM_STATUS_OFS = 8'h04;
    localparam logic [7:0] LPM_CTCS_OFS = 8'h08;
    localparam logic [7:0] LPM_WDOG_OFS = 8'h0c;
    // CTRL fields
    localparam int CTRL_ULP_BIT = 0;
    localparam int CTRL_STOP_DIS_BIT = 1;
    localparam int CTRL_TIMER_OFF_BIT = 2;
    localparam int CTRL_WD_CLR_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // Core timer control/status: flags [7:6], enables [5:4], rest [3:0]
    localparam logic [7:0] CTCS_FLAG_IE_MASK = 8'hf0;
    localparam logic [7:0] CTCS_RESET = 8'h00;
    localparam int PRESCALE_W = 13;
    localparam logic [12:0] PRESCALE_RESET = 13'h0000;
    localparam int WDOG_W = 16;
    localparam logic [15:0] WDOG_RESET = 16'h0000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int STARTUP_CYCLES = 4064;
    localparam int STARTUP_W = 12;
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        LPM_RUN = 6'b00_0001,
        LPM_WAIT = 6'b00_0010,
        LPM_STOP = 6'b00_0100,
        LPM_REG_UP = 6'b00_1000,
        LPM_STARTUP = 6'b01_0000,
        LPM_STOP_RST = 6'b10_0000
    } lpm_state_t;
endpackage

// ### rtl/lpm_startup_cnt.sv
`timescale 1ns/1ns
module lpm_startup_cnt #(
    parameter int COUNT = 4064
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (start) begin
            cnt_next = 12'(COUNT - 1);
        end else if (busy) begin
            cnt_next = cnt_reg - 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 12'h000;
            busy <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            if (start) begin
                busy <= 1'b1;
            end else if (busy && cnt_reg == 12'h000) begin
                busy <= 1'b0;
            end
        end
    end

    assign done = busy && (cnt_reg == 12'h000) && !start;
endmodule // lpm_startup_cnt

// ### rtl/lpm_mode_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - At reset release, test level on irq and mode pin high gives monitor.
// - Stop halts oscillator, core timer and watchdog counting.
// - Entering stop clears core timer flags and interrupt enables.
// - Entering stop clears the core timer prescaler.
// - Entering stop clears the interrupt mask bit.
// - Other state, timer bits and port lines hold during stop.
// - Stop ends only on external, exception, wake-up interrupt or reset.
// - With stop disabled, a stop instruction requests a system reset.
// - Ultra-low-power submode exists only when the build parameter allows.
// - Ultra-low-power bit forces ports, amplifier, monitors into low power.
// - ULP stop turns regulator off; recovery waits for supply threshold.
// - Wait suspends CPU; core timer, PWM and 16-bit timer may run.
// - Enabled core timer or peripheral interrupt ends wait.
// - Entering wait clears interrupt mask, other state kept.
// - Stop wake-up waits 4064 cycles, clock monitor suspended meanwhile.
// - Reset wake holds watchdog cleared; interrupt wake lets it count up from the stop-entry clear through startup.
module lpm_mode_ctrl
    import lpm_pkg::*;
#(
    parameter bit ULP_AVAILABLE = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_test_level,
    input wire logic mode_select_pin,
    input wire logic stop_instr,
    input wire logic wait_instr,
    input wire logic ext_irq,
    input wire logic exception_irq,
    input wire logic wakeup_irq,
    input wire logic periph_irq,
    input wire logic wake_reset,
    input wire logic vdd_above_lvr,
    input wire logic ccr_i_set,
    output logic monitor_mode,
    output logic cpu_halt,
    output logic osc_enable,
    output logic core_timer_run,
    output logic timer16_run,
    output logic pwm_run,
    output logic clock_monitor_en,
    output logic ccr_i_clear,
    output logic irq_entry,
    output logic stop_reset_req,
    output logic regulator_on,
    output logic hv_low_force_input,
    output logic hv_drv_off,
    output logic amp_debias,
    output logic monitors_off,
    output logic [7:0] core_timer_ctrl_status,
    output logic [lpm_pkg::PRESCALE_W-1:0] prescale_count,
    output logic [lpm_pkg::WDOG_W-1:0] watchdog_counter
);
    import lpm_pkg::*;

    lpm_state_t state_reg;
    lpm_state_t state_next;
    logic [3:0] ctrl_reg;
    logic first_reg;
    logic woke_by_reset_reg;
    logic start_go;
    logic start_busy;
    logic start_done;
    logic wr_en;
    logic ct_irq;
    logic stop_wake;
    logic ulp_bit;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign ulp_bit = ULP_AVAILABLE && ctrl_reg[CTRL_ULP_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && paddr == LPM_CTRL_OFS) begin
            ctrl_reg <= pwdata[3:0];
        end else begin
            ctrl_reg[CTRL_WD_CLR_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                LPM_CTRL_OFS: prdata <= {28'h000_0000, ctrl_reg};
                LPM_STATUS_OFS: prdata <= {26'h000_0000, state_reg};
                LPM_CTCS_OFS: prdata <= {24'h00_0000, core_timer_ctrl_status};
                LPM_WDOG_OFS: prdata <= {16'h0000, watchdog_counter};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode latch at reset release
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b1;
            monitor_mode <= 1'b0;
        end else if (first_reg) begin
            first_reg <= 1'b0;
            monitor_mode <= irq_test_level && mode_select_pin;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign ct_irq = |(core_timer_ctrl_status[7:6] & core_timer_ctrl_status[5:4]);
    assign stop_wake = ext_irq || exception_irq || wakeup_irq || wake_reset;

    always_comb begin
        state_next = state_reg;
        start_go = 1'b0;
        unique case (state_reg)
            LPM_RUN: begin
                if (stop_instr && ctrl_reg[CTRL_STOP_DIS_BIT]) begin
                    state_next = LPM_STOP_RST;
                end else if (stop_instr) begin
                    state_next = LPM_STOP;
                end else if (wait_instr) begin
                    state_next = LPM_WAIT;
                end
            end
            LPM_WAIT: begin
                if (ct_irq || periph_irq || ext_irq || wake_reset) begin
                    state_next = LPM_RUN;
                end
            end
            LPM_STOP: begin
                if (stop_wake && ulp_bit) begin
                    state_next = LPM_REG_UP;
                end else if (stop_wake) begin
                    state_next = LPM_STARTUP;
                    start_go = 1'b1;
                end
            end
            LPM_REG_UP: begin
                if (vdd_above_lvr) begin
                    state_next = LPM_STARTUP;
                    start_go = 1'b1;
                end
            end
            LPM_STARTUP: begin
                if (start_done) begin
                    state_next = LPM_RUN;
                end
            end
            LPM_STOP_RST: state_next = LPM_RUN;
            default: state_next = LPM_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= LPM_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            woke_by_reset_reg <= 1'b0;
        end else if ((state_reg == LPM_STOP) && stop_wake) begin
            woke_by_reset_reg <= wake_reset;
        end
    end

    lpm_startup_cnt #(
        .COUNT(STARTUP_CYCLES)
    ) u_startup (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_go),
        .busy(start_busy),
        .done(start_done)
    );

    // ------------------------------------------------------------
    // Outputs toward core and analogue
    // ------------------------------------------------------------
    logic in_stop;
    assign in_stop = (state_reg == LPM_STOP) || (state_reg == LPM_REG_UP);
    assign cpu_halt = (state_reg != LPM_RUN);
    assign osc_enable = !in_stop;
    assign core_timer_run = (state_reg == LPM_RUN)
                            || (state_reg == LPM_WAIT);
    assign timer16_run = core_timer_run && !ctrl_reg[CTRL_TIMER_OFF_BIT];
    assign pwm_run = core_timer_run;
    assign clock_monitor_en = !in_stop && !start_busy;
    assign ccr_i_clear = ccr_i_set && (state_reg == LPM_RUN)
                         && (stop_instr || wait_instr);
    assign irq_entry = (state_next == LPM_RUN) && (state_reg != LPM_RUN)
                       && (state_reg != LPM_STOP_RST);
    assign stop_reset_req = (state_reg == LPM_STOP_RST);
    assign regulator_on = !((state_reg == LPM_STOP) && ulp_bit);
    assign hv_low_force_input = ulp_bit;
    assign hv_drv_off = ulp_bit;
    assign amp_debias = ulp_bit;
    assign monitors_off = ulp_bit;

    // ------------------------------------------------------------
    // Core timer, prescaler and watchdog
    // ------------------------------------------------------------
    logic entering_stop;
    assign entering_stop = (state_reg == LPM_RUN) && stop_instr
                           && !ctrl_reg[CTRL_STOP_DIS_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_timer_ctrl_status <= CTCS_RESET;
        end else if (entering_stop) begin
            core_timer_ctrl_status <= core_timer_ctrl_status
                                      & ~CTCS_FLAG_IE_MASK;
        end else if (wr_en && paddr == LPM_CTCS_OFS) begin
            core_timer_ctrl_status <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count <= PRESCALE_RESET;
        end else if (entering_stop) begin
            prescale_count <= PRESCALE_RESET;
        end else if (core_timer_run) begin
            prescale_count <= prescale_count + 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_counter <= WDOG_RESET;
        end else if (ctrl_reg[CTRL_WD_CLR_BIT] || entering_stop) begin
            watchdog_counter <= WDOG_RESET;
        end else if (state_reg == LPM_STARTUP && woke_by_reset_reg) begin
            watchdog_counter <= WDOG_RESET;
        end else if (core_timer_run || state_reg == LPM_STARTUP) begin
            watchdog_counter <= watchdog_counter + 16'h0001;
        end
    end
endmodule // lpm_mode_ctrl

// ### sim/lpm_chk_asserts.sv
`timescale 1ns/1ns
module lpm_chk
    import lpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wait_instr,
    input wire logic ext_irq,
    input wire logic exception_irq,
    input wire logic wakeup_irq,
    input wire logic wake_reset,
    input wire logic ccr_i_set,
    input wire logic monitor_mode,
    input wire logic cpu_halt,
    input wire logic osc_enable,
    input wire logic core_timer_run,
    input wire logic clock_monitor_en,
    input wire logic ccr_i_clear,
    input wire logic stop_reset_req,
    input wire logic regulator_on,
    input wire logic hv_low_force_input,
    input wire logic hv_drv_off,
    input wire logic amp_debias,
    input wire logic monitors_off,
    input wire logic [7:0] core_timer_ctrl_status,
    input wire logic [lpm_pkg::PRESCALE_W-1:0] prescale_count,
    input wire logic [lpm_pkg::WDOG_W-1:0] watchdog_counter
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] age_reg;
    logic [12:0] run_reg;
    logic dozed_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age_reg <= 2'h0;
        else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
    // Cycles halted with oscillator back on after a stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 13'h0000;
            dozed_reg <= 1'h0;
        end else if (!osc_enable) begin
            run_reg <= 13'h0000;
            dozed_reg <= 1'h1;
        end else if (cpu_halt) begin
            run_reg <= run_reg + 13'h0001;
        end else begin
            run_reg <= 13'h0000;
            dozed_reg <= 1'h0;
        end
    end
    sequence s_stop_entry;
        $fell(osc_enable);
    endsequence
    chk_mode_held: assert property (
        age_reg == 2'h3 |-> $stable(monitor_mode)) else $error("mode moved");
    chk_osc_halt: assert property (
        !osc_enable |-> cpu_halt && !core_timer_run) else $error("osc off");
    chk_wdog_frozen: assert property (
        !osc_enable && !$past(osc_enable) |-> $stable(watchdog_counter))
        else $error("wdog moved");
    chk_stop_clear: assert property (
        s_stop_entry |-> (core_timer_ctrl_status & CTCS_FLAG_IE_MASK) == 8'h00
        && prescale_count == PRESCALE_RESET) else $error("stop clear");
    chk_stop_hold: assert property (
        !osc_enable && !hv_low_force_input && !(ext_irq || exception_irq ||
        wakeup_irq || wake_reset) |=> !osc_enable) else $error("bad wake");
    chk_wait_iclr: assert property (
        wait_instr && !cpu_halt && ccr_i_set |-> ccr_i_clear)
        else $error("I kept");
    chk_start_len: assert property (
        $fell(cpu_halt) && dozed_reg |-> run_reg inside {[4063:4067]})
        else $error("startup len");
    chk_clkmon_off: assert property (
        cpu_halt && dozed_reg |-> !clock_monitor_en) else $error("clkmon");
    chk_ulp_group: assert property (
        hv_low_force_input |-> hv_drv_off && amp_debias && monitors_off)
        else $error("ulp group");
    chk_reg_off: assert property (
        !regulator_on |-> !osc_enable && hv_low_force_input)
        else $error("regulator");
    chk_rst_pulse: assert property (
        stop_reset_req |-> osc_enable ##1 !stop_reset_req)
        else $error("reset pulse");
endmodule // lpm_chk
bind lpm_mode_ctrl lpm_chk i_lpm_chk (.*);

// ### sim/lpm_cpu_model.sv
`timescale 1ns/1ns
module lpm_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic do_stop,
    input wire logic do_wait,
    input wire logic cpu_halt,
    input wire logic ccr_i_clear,
    input wire logic irq_entry,
    output logic stop_instr,
    output logic wait_instr,
    output logic ccr_i_set
);
    // Nothing issued while suspended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_instr <= 1'h0;
            wait_instr <= 1'h0;
        end else begin
            stop_instr <= do_stop && !cpu_halt;
            wait_instr <= do_wait && !cpu_halt;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ccr_i_set <= 1'h1;
        else if (irq_entry) ccr_i_set <= 1'h1;
        else if (ccr_i_clear) ccr_i_set <= 1'h0;
    end
endmodule // lpm_cpu_model

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import lpm_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, irq_test_level = 1'h0, mode_select_pin = 1'h0;
    logic ext_irq = 1'h0, exception_irq = 1'h0, wakeup_irq = 1'h0;
    logic periph_irq = 1'h0, wake_reset = 1'h0, vdd_above_lvr = 1'h1;
    logic do_stop = 1'h0, do_wait = 1'h0, stop_instr, wait_instr, ccr_i_set;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, monitor_mode, cpu_halt, osc_enable, core_timer_run;
    logic timer16_run, pwm_run, clock_monitor_en, ccr_i_clear, irq_entry;
    logic stop_reset_req, regulator_on, hv_low_force_input, hv_drv_off;
    logic amp_debias, monitors_off;
    logic [7:0] core_timer_ctrl_status;
    logic [PRESCALE_W-1:0] prescale_count;
    logic [WDOG_W-1:0] watchdog_counter;
    logic [31:0] exp_q[$];
    int mismatches = 0, cmp_count = 0, entries = 0;
    lpm_mode_ctrl #(.ULP_AVAILABLE(1'h1)) i_lpm_mode_ctrl (.*);
    lpm_cpu_model i_lpm_cpu_model (.*);
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (irq_entry === 1'h1) entries++;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            wrap_up();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        apb(1'h0, a, 32'h0000_0000);
    endtask
    always @(posedge pclk)
        if (psel && penable && !pwrite && pready)
            check(prdata, exp_q.pop_front());
    task automatic await_run(output int n);
        n = 0;
        while (cpu_halt !== 1'h0 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 5000) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic pulse_stop;
        do_stop <= 1'h1;
        @(posedge pclk);
        do_stop <= 1'h0;
        tick(2);
    endtask
    initial begin
        int n, m;
        n = $urandom(32'hb8f2fd27);
        for (int i = 3; i >= 0; i--) begin
            irq_test_level <= i[0];
            mode_select_pin <= i[1];
            presetn <= 1'h0;
            tick(6);
            presetn <= 1'h1;
            tick(2);
            check(monitor_mode, i[0] & i[1]);
            {irq_test_level, mode_select_pin} <= 2'($urandom);
            tick(3);
            check(monitor_mode, i[0] & i[1]);
        end
        rd(LPM_STATUS_OFS, 32'h0000_0001);
        rd(8'h10, 32'h0000_0000);
        check(pslverr, 1'h0);
        for (int w = 0; w < 4; w++) begin
            apb(1'h1, LPM_CTCS_OFS, 32'h0000_00ff);
            m = entries;
            pulse_stop();
            check(osc_enable, 1'h0);
            check(core_timer_ctrl_status, 8'h0f);
            check(prescale_count, PRESCALE_RESET);
            check(ccr_i_set, 1'h0);
            periph_irq <= 1'h1;
            tick(5 + $urandom % 20);
            check(osc_enable, 1'h0);
            periph_irq <= 1'h0;
            {wake_reset, wakeup_irq, exception_irq, ext_irq} <= 4'h1 << w;
            @(posedge pclk);
            {wake_reset, wakeup_irq, exception_irq, ext_irq} <= 4'h0;
            await_run(n);
            check(n inside {[4063:4067]}, 1'h1);
            if (w == 3) check(watchdog_counter, WDOG_RESET);
            else check(watchdog_counter, STARTUP_CYCLES);
            tick(2);
            check(entries - m, 1);
        end
        m = entries;
        do_wait <= 1'h1;
        @(posedge pclk);
        do_wait <= 1'h0;
        tick(2);
        check(ccr_i_set, 1'h0);
        check({cpu_halt, osc_enable, core_timer_run, timer16_run, pwm_run},
              5'h1f);
        apb(1'h1, LPM_CTRL_OFS, 32'h0000_0004);
        tick(1);
        check(timer16_run, 1'h0);
        periph_irq <= 1'h1;
        @(posedge pclk);
        periph_irq <= 1'h0;
        await_run(n);
        check(n < 8, 1'h1);
        tick(2);
        check(entries - m, 1);
        do_wait <= 1'h1;
        @(posedge pclk);
        do_wait <= 1'h0;
        tick(2);
        apb(1'h1, LPM_CTCS_OFS, 32'h0000_00f0);
        await_run(n);
        check(n < 4, 1'h1);
        apb(1'h1, LPM_CTRL_OFS, 32'h0000_0002);
        do_stop <= 1'h1;
        @(posedge pclk);
        do_stop <= 1'h0;
        n = 0;
        repeat (6) begin
            @(posedge pclk);
            n += stop_reset_req;
        end
        check(n, 1);
        check(osc_enable, 1'h1);
        apb(1'h1, LPM_CTRL_OFS, 32'h0000_0001);
        tick(1);
        check({hv_low_force_input, hv_drv_off, amp_debias, monitors_off},
              4'hf);
        vdd_above_lvr <= 1'h0;
        pulse_stop();
        check(regulator_on, 1'h0);
        ext_irq <= 1'h1;
        @(posedge pclk);
        ext_irq <= 1'h0;
        tick(20);
        check({regulator_on, cpu_halt}, 2'h3);
        vdd_above_lvr <= 1'h1;
        await_run(n);
        check(n inside {[4063:4068]}, 1'h1);
        apb(1'h1, LPM_CTRL_OFS, 32'h0000_0000);
        tick(1);
        check(hv_low_force_input, 1'h0);
        wrap_up();
    end
endmodule // tb_top
